// ===== src/dsdwd_top.sv
`timescale 1ns/10ps
module dsdwd_top
	import dsdwd_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  spi_sclk_in,
	input  wire logic                  spi_cs_n_in,
	input  wire logic                  spi_din_in,
	input  wire logic [ADDR_BITS-1:0]  reg_addr_in,
	input  wire logic [DATA_BITS-1:0]  reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic [DATA_BITS-1:0]       reg_rdata_out,
	output logic                       word_ready_out,
	output logic [CODE_BITS-1:0]       dac_a_code_out,
	output logic [CODE_BITS-1:0]       dac_b_code_out,
	output logic                       speed_fast_out,
	output logic                       power_down_out
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic                 cs_m;
		logic                 cs_s;
		logic                 cs_d;
		logic                 sck_m;
		logic                 sck_s;
		logic                 sck_d;
		logic                 din_m;
		logic                 din_s;
		logic [WORD_BITS-1:0] shift;
		logic [3:0]           cnt;
		logic [CODE_BITS-1:0] dac_a;
		logic [CODE_BITS-1:0] dac_b;
		logic [CODE_BITS-1:0] buffer;
		logic                 speed;
		logic                 pd;
		logic                 hold;
		logic                 ovf;
		logic [DATA_BITS-1:0] rd_data;
	} dsdwd_state_t;

	dsdwd_state_t          st_ff;
	dsdwd_state_t          nxt_st;

	logic                  cs_high;
	logic                  cs_rise;
	logic                  cs_fall;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  bit_take;
	logic                  push_valid;
	dsdwd_word_t           push_word;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	dsdwd_word_t           fifo_out_word;
	logic [LEVEL_BITS-1:0] fifo_level;
	logic                  apply;
	dsdwd_word_t           aw;
	dsdwd_sel_t            sel;

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised pins

	assign cs_high  = st_ff.cs_s;
	assign cs_rise  = st_ff.cs_s && !st_ff.cs_d;
	assign cs_fall  = !st_ff.cs_s && st_ff.cs_d;
	assign sck_rise = st_ff.sck_s && !st_ff.sck_d;
	assign sck_fall = !st_ff.sck_s && st_ff.sck_d;
	assign bit_take = sck_fall && !cs_high && !cs_fall;

	////////////////////////////////////////////////////////////////////////
	// Word buffer between the serial side and the latches

	dsdwd_fifo #(
		.WIDTH ($bits(dsdwd_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (push_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (push_word),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_word),
		.level_out     (fifo_level)
	);

	// Words wait for the next rising serial clock, or for an idle select
	// when the host stops the clock after the frame.
	assign fifo_out_ready = !st_ff.hold && (sck_rise || cs_high);
	assign apply          = fifo_out_valid && fifo_out_ready;
	assign aw             = fifo_out_word;
	assign sel            = dsdwd_sel_t'({aw.select_high_bit,
	                                      aw.select_low_bit});
	assign word_ready_out = fifo_in_ready;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_st     = st_ff;
		push_valid = 1'b0;
		push_word  = st_ff.shift;

		nxt_st.cs_m  = spi_cs_n_in;
		nxt_st.cs_s  = st_ff.cs_m;
		nxt_st.cs_d  = st_ff.cs_s;
		nxt_st.sck_m = spi_sclk_in;
		nxt_st.sck_s = st_ff.sck_m;
		nxt_st.sck_d = st_ff.sck_s;
		nxt_st.din_m = spi_din_in;
		nxt_st.din_s = st_ff.din_m;

		// Serial shifter
		if (cs_rise) begin
			nxt_st.cnt = BIT_CNT_ZERO;
			if (st_ff.cnt != BIT_CNT_ZERO) begin
				push_valid = 1'b1;
			end
		end else if (cs_high) begin
			nxt_st.cnt = BIT_CNT_ZERO;
		end else if (cs_fall) begin
			nxt_st.cnt   = BIT_CNT_ZERO;
			nxt_st.shift = '0;
		end else if (bit_take) begin
			nxt_st.shift = {st_ff.shift[WORD_BITS-2:0], st_ff.din_s};
			nxt_st.cnt   = st_ff.cnt + 4'h1;
			if (st_ff.cnt == BIT_CNT_LAST) begin
				push_valid = 1'b1;
				push_word  = {st_ff.shift[WORD_BITS-2:0], st_ff.din_s};
			end
		end

		// Decode and update of the latches
		if (apply) begin
			if (aw.power_down_bit) begin
				nxt_st.pd = 1'b1;
			end else begin
				unique case (sel)
					SEL_DAC_B_BUF: begin
						nxt_st.pd     = 1'b0;
						nxt_st.speed  = aw.speed_select_bit;
						nxt_st.dac_b  = aw.value;
						nxt_st.buffer = aw.value;
					end
					SEL_BUF_ONLY: begin
						nxt_st.pd     = 1'b0;
						nxt_st.speed  = aw.speed_select_bit;
						nxt_st.buffer = aw.value;
					end
					SEL_DAC_A_XFER: begin
						nxt_st.pd    = 1'b0;
						nxt_st.speed = aw.speed_select_bit;
						nxt_st.dac_a = aw.value;
						nxt_st.dac_b = st_ff.buffer;
					end
					SEL_RESERVED: begin
						nxt_st.pd = st_ff.pd;
					end
				endcase
			end
		end

		// Register writes; a lost word beats a clear in the same cycle
		if (reg_wr_in && reg_addr_in == REG_CTRL) begin
			nxt_st.hold = reg_wdata_in[CTRL_HOLD_POS];
		end
		if (reg_wr_in && reg_addr_in == REG_STATUS &&
		    reg_wdata_in[STAT_OVF_POS]) begin
			nxt_st.ovf = 1'b0;
		end
		if (push_valid && !fifo_in_ready) begin
			nxt_st.ovf = 1'b1;
		end

		// Register reads, data valid in the next cycle only
		nxt_st.rd_data = '0;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CTRL: begin
					nxt_st.rd_data[CTRL_HOLD_POS] = st_ff.hold;
				end
				REG_STATUS: begin
					nxt_st.rd_data[STAT_OVF_POS]  = st_ff.ovf;
					nxt_st.rd_data[STAT_FAST_POS] = st_ff.speed;
					nxt_st.rd_data[STAT_PD_POS]   = st_ff.pd;
					nxt_st.rd_data[STAT_LEVEL_LSB +: LEVEL_BITS] = fifo_level;
				end
				REG_DAC_A: begin
					nxt_st.rd_data[CODE_BITS-1:0] = st_ff.dac_a;
				end
				REG_DAC_B: begin
					nxt_st.rd_data[CODE_BITS-1:0] = st_ff.dac_b;
				end
				REG_BUFFER: begin
					nxt_st.rd_data[CODE_BITS-1:0] = st_ff.buffer;
				end
				default: begin
					nxt_st.rd_data = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff        <= '0;
			st_ff.cs_m   <= PIN_IDLE_RESET; // Idle pin levels, no false edge
			st_ff.cs_s   <= PIN_IDLE_RESET;
			st_ff.cs_d   <= PIN_IDLE_RESET;
			st_ff.sck_m  <= PIN_IDLE_RESET;
			st_ff.sck_s  <= PIN_IDLE_RESET;
			st_ff.sck_d  <= PIN_IDLE_RESET;
			st_ff.dac_a  <= CODE_RESET;
			st_ff.dac_b  <= CODE_RESET;
			st_ff.buffer <= CODE_RESET;
			st_ff.speed  <= SPEED_RESET;
			st_ff.pd     <= PD_RESET;
			st_ff.hold   <= HOLD_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs toward the converter section

	assign dac_a_code_out = st_ff.dac_a;
	assign dac_b_code_out = st_ff.dac_b;
	assign speed_fast_out = st_ff.speed;
	assign power_down_out = st_ff.pd;
	assign reg_rdata_out  = st_ff.rd_data;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_word_length: assert property (
		bit_take && st_ff.cnt == BIT_CNT_LAST |-> push_valid
		##1 st_ff.cnt == BIT_CNT_ZERO)
		else $error("sixteenth bit did not complete a word");

	a_msb_first: assert property (
		bit_take |=> st_ff.shift[0] == $past(st_ff.din_s)
		&& st_ff.shift[WORD_BITS-1:1] == $past(st_ff.shift[WORD_BITS-2:0]))
		else $error("serial bit not shifted in msb first");

	a_partial_push: assert property (
		cs_rise && st_ff.cnt != BIT_CNT_ZERO |-> push_valid
		&& push_word == st_ff.shift)
		else $error("short frame not moved on select rise");

	a_apply_edge: assert property (
		!apply |=> $stable(dac_a_code_out) && $stable(dac_b_code_out)
		&& $stable(speed_fast_out) && $stable(power_down_out))
		else $error("outputs changed without an applied word");

	a_buf_stable: assert property (
		!apply |=> $stable(st_ff.buffer))
		else $error("holding buffer changed without an applied word");

	a_partial_none: assert property (
		cs_rise && st_ff.cnt == BIT_CNT_ZERO |-> !push_valid)
		else $error("empty frame pushed a word");

	a_pd_enter: assert property (
		apply && aw.power_down_bit |=> power_down_out
		&& $stable(dac_a_code_out) && $stable(dac_b_code_out)
		&& $stable(speed_fast_out))
		else $error("power-down word did not act alone");

	a_speed_take: assert property (
		apply && !aw.power_down_bit && sel != SEL_RESERVED
		|=> speed_fast_out == $past(aw.speed_select_bit) && !power_down_out)
		else $error("speed select not taken from the word");

	a_sel_b_buf: assert property (
		apply && !aw.power_down_bit && sel == SEL_DAC_B_BUF
		|=> dac_b_code_out == $past(aw.value)
		&& st_ff.buffer == $past(aw.value) && $stable(dac_a_code_out))
		else $error("select 00 did not write channel b and buffer");

	a_sel_buf: assert property (
		apply && !aw.power_down_bit && sel == SEL_BUF_ONLY
		|=> st_ff.buffer == $past(aw.value)
		&& $stable(dac_a_code_out) && $stable(dac_b_code_out))
		else $error("select 01 touched an output");

	a_sel_a_xfer: assert property (
		apply && !aw.power_down_bit && sel == SEL_DAC_A_XFER
		|=> dac_a_code_out == $past(aw.value)
		&& dac_b_code_out == $past(st_ff.buffer))
		else $error("select 10 did not update both channels");

	a_reserved: assert property (
		apply && !aw.power_down_bit && sel == SEL_RESERVED
		|=> $stable(st_ff.dac_a) && $stable(st_ff.dac_b)
		&& $stable(st_ff.buffer) && $stable(st_ff.speed)
		&& $stable(st_ff.pd))
		else $error("reserved select changed state");

	a_ovf_sticky: assert property (
		push_valid && !fifo_in_ready |=> st_ff.ovf)
		else $error("lost word not flagged");

	a_ovf_clear: assert property (
		reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[STAT_OVF_POS]
		&& !(push_valid && !fifo_in_ready) |=> !st_ff.ovf)
		else $error("overflow flag not cleared by write");

	a_full_refuse: assert property (
		fifo_level == LEVEL_BITS'(FIFO_DEPTH) |-> !word_ready_out)
		else $error("full buffer still reports ready");

	a_rd_one_cycle: assert property (
		!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data outside its cycle");

endmodule : dsdwd_top

// ===== src/dsdwd_pkg.sv
package dsdwd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Serial word
	localparam int WORD_BITS        = 16;
	localparam int CODE_BITS        = 12;
	localparam int UPDATE_MAX_KHZ   = 1250;
	localparam logic [3:0] BIT_CNT_LAST = 4'hf;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// Buffering
	localparam int FIFO_DEPTH       = 16;
	localparam int LEVEL_BITS       = 5;

	////////////////////////////////////////////////////////////////////////
	// Register port
	localparam int ADDR_BITS        = 4;
	localparam int DATA_BITS        = 32;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_DAC_A  = 4'h2;
	localparam logic [3:0] REG_DAC_B  = 4'h3;
	localparam logic [3:0] REG_BUFFER = 4'h4;
	localparam int CTRL_HOLD_POS    = 0;
	localparam int STAT_OVF_POS     = 0;
	localparam int STAT_FAST_POS    = 1;
	localparam int STAT_PD_POS      = 2;
	localparam int STAT_LEVEL_LSB   = 8;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [11:0] CODE_RESET  = 12'h000;
	localparam logic        SPEED_RESET = 1'b0;
	localparam logic        PD_RESET    = 1'b0;
	localparam logic        HOLD_RESET  = 1'b0;
	localparam logic        PIN_IDLE_RESET = 1'b1;

	typedef enum logic [1:0] {
		SEL_DAC_B_BUF  = 2'b00,
		SEL_BUF_ONLY   = 2'b01,
		SEL_DAC_A_XFER = 2'b10,
		SEL_RESERVED   = 2'b11
	} dsdwd_sel_t;

	typedef struct packed {
		logic        select_high_bit;
		logic        speed_select_bit;
		logic        power_down_bit;
		logic        select_low_bit;
		logic [11:0] value;
	} dsdwd_word_t;

endpackage : dsdwd_pkg

// ===== src/dsdwd_fifo.sv
`timescale 1ns/10ps
module dsdwd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       in_valid_in,
	output logic                            in_ready_out,
	input  wire logic [WIDTH-1:0]           in_data_in,
	output logic                            out_valid_out,
	input  wire logic                       out_ready_in,
	output logic [WIDTH-1:0]                out_data_out,
	output logic [$clog2(DEPTH+1)-1:0]      level_out
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH-1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
	} dsdwd_fifo_st_t;

	dsdwd_fifo_st_t st_ff;
	dsdwd_fifo_st_t nxt_st;
	logic           push;
	logic           pop;

	assign in_ready_out  = (st_ff.cnt != CNT_FULL);
	assign out_valid_out = (st_ff.cnt != '0);
	assign out_data_out  = st_ff.mem[st_ff.rd];
	assign level_out     = st_ff.cnt;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wr] = in_data_in;
			nxt_st.wr = (st_ff.wr == PTR_LAST) ? '0 : st_ff.wr + 1'b1;
		end
		if (pop) begin
			nxt_st.rd = (st_ff.rd == PTR_LAST) ? '0 : st_ff.rd + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = st_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : dsdwd_fifo

// ===== verification/dsdwd_host_model.sv
`timescale 1ns/10ps
module dsdwd_host_model (
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out
);
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		din_out  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One frame, 125 ns clock; the clock stands high between frames
	task automatic send_bits(input logic [15:0] w, input int n);
		cs_n_out = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			din_out = w[i];
			#62.5;
			sclk_out = 1'b0;
			#62.5;
			sclk_out = 1'b1;
		end
		#62.5;
		din_out  = ~din_out;
		cs_n_out = 1'b1;
		#100;
	endtask : send_bits
endmodule : dsdwd_host_model

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb
	import dsdwd_pkg::*;
;
	logic                 clk_in;
	logic                 reset_n_in;
	logic [ADDR_BITS-1:0] reg_addr;
	logic [DATA_BITS-1:0] reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [DATA_BITS-1:0] reg_rdata;
	logic                 word_ready;
	logic [CODE_BITS-1:0] dac_a;
	logic [CODE_BITS-1:0] dac_b;
	logic                 fast;
	logic                 pd;
	logic                 sclk;
	logic                 cs_n;
	logic                 din;
	int                   fail_count = 0;
	int                   checked = 0;
	int                   cycles = 0;

	dsdwd_host_model host_u (
		.sclk_out (sclk),
		.cs_n_out (cs_n),
		.din_out  (din)
	);

	dsdwd_top dut_u (
		.clk_in         (clk_in),
		.reset_n_in     (reset_n_in),
		.spi_sclk_in    (sclk),
		.spi_cs_n_in    (cs_n),
		.spi_din_in     (din),
		.reg_addr_in    (reg_addr),
		.reg_wdata_in   (reg_wdata),
		.reg_wr_in      (reg_wr),
		.reg_rd_in      (reg_rd),
		.reg_rdata_out  (reg_rdata),
		.word_ready_out (word_ready),
		.dac_a_code_out (dac_a),
		.dac_b_code_out (dac_b),
		.speed_fast_out (fast),
		.power_down_out (pd)
	);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_in);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_in);
		reg_rd   <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask : rd

	task automatic chk_out(input logic [11:0] a, input logic [11:0] b,
			input logic [11:0] bf, input logic f, input logic p);
		#1;
		cmp({20'h0, dac_a}, {20'h0, a});
		cmp({20'h0, dac_b}, {20'h0, b});
		cmp({31'h0, fast}, {31'h0, f});
		cmp({31'h0, pd}, {31'h0, p});
		rd(REG_BUFFER, {20'h0, bf});
		rd(REG_DAC_A, {20'h0, a});
		rd(REG_DAC_B, {20'h0, b});
		rd(REG_STATUS, {29'h0, p, f, 1'b0});
	endtask : chk_out

	task automatic send(input logic [15:0] w);
		host_u.send_bits(w, 16);
		repeat (10) @(posedge clk_in);
	endtask : send

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		chk_out(12'h000, 12'h000, 12'h000, 1'b0, 1'b0);
		rd(4'h7, 32'h0);
		wr(REG_BUFFER, 32'h123);
		rd(REG_BUFFER, 32'h0);
	endtask : t_reset

	task automatic t_selects;
		send(16'h4abc);
		chk_out(12'h000, 12'habc, 12'habc, 1'b1, 1'b0);
		send(16'h1123);
		chk_out(12'h000, 12'habc, 12'h123, 1'b0, 1'b0);
		send(16'h8456);
		chk_out(12'h456, 12'h123, 12'h123, 1'b0, 1'b0);
		send(16'h9fff);
		chk_out(12'h456, 12'h123, 12'h123, 1'b0, 1'b0);
		send(16'hffff);
		chk_out(12'h456, 12'h123, 12'h123, 1'b0, 1'b1);
		send(16'hc001);
		chk_out(12'h001, 12'h123, 12'h123, 1'b1, 1'b0);
	endtask : t_selects

	task automatic t_short;
		host_u.send_bits(16'h00a5, 8);
		repeat (10) @(posedge clk_in);
		chk_out(12'h001, 12'h0a5, 12'h0a5, 1'b0, 1'b0);
	endtask : t_short

	task automatic t_fifo;
		wr(REG_CTRL, 32'h1);
		rd(REG_CTRL, 32'h1);
		for (int i = 0; i < 17; i++) begin
			host_u.send_bits(16'(i), 16);
		end
		repeat (5) @(posedge clk_in);
		cmp({31'h0, word_ready}, 32'h0);
		cmp({20'h0, dac_b}, 32'h0a5);
		rd(REG_STATUS, 32'h1001);
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS, 32'h1000);
		wr(REG_CTRL, 32'h0);
		repeat (40) @(posedge clk_in);
		cmp({31'h0, word_ready}, 32'h1);
		chk_out(12'h001, 12'h00f, 12'h00f, 1'b0, 1'b0);
	endtask : t_fifo

	task automatic t_edge;
		fork
			host_u.send_bits(16'h8321, 16);
			begin
				@(posedge cs_n);
				#1;
				cmp({20'h0, dac_a}, 32'h321);
				cmp({20'h0, dac_b}, 32'h00f);
			end
		join
		repeat (10) @(posedge clk_in);
		chk_out(12'h321, 12'h00f, 12'h00f, 1'b0, 1'b0);
	endtask : t_edge

	initial begin
		reset_n_in = 1'b0;
		reg_addr   = '0;
		reg_wdata  = '0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		repeat (4) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_reset();
		t_selects();
		t_short();
		t_fifo();
		t_edge();
		wrap_up();
	end
endmodule : tb
